// ---- sdm_top.sv ----
// Supply drop monitor controller with APB registers, flag, interrupt and wake logic.
`timescale 1ns/100ps
`default_nettype none
module sdm_top
    import sdm_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
)
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Analog side
    input  wire logic        i_cmp_above,
    input  wire logic        i_osc_run,
    output logic             o_det_power,
    output logic [2:0]       o_trip_level,
    // Core side
    input  wire logic        i_first_insn_done,
    output logic             o_irq,
    output logic             o_wake,
    output logic             o_vector
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic       enable_r;
    logic [2:0] level_r;
    logic [7:0] irq_ctrl_r;
    logic [7:0] pie_r;
    logic [7:0] pir_r;
    logic       sleep_r;
    logic       vec_pend_r;
    logic       stable;
    logic       cmp_fall;
    logic       cmp_level;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
        hit = (a == base);
    endfunction : hit

    wire logic wr_acc = i_psel & i_penable & i_pwrite & i_pstrb[0];
    wire logic rd_acc = i_psel & ~i_penable & ~i_pwrite;
    wire logic mapped = hit(i_paddr, ADDR_MON_CTRL) | hit(i_paddr, ADDR_IRQ_CTRL) | hit(i_paddr, ADDR_PIE_SEC)
                      | hit(i_paddr, ADDR_PIR_SEC) | hit(i_paddr, ADDR_SLEEP);

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    sdm_sync u_sync
    (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (i_cmp_above),
        .o_level   (cmp_level),
        .o_fall    (cmp_fall)
    );

    sdm_settle #(.SETTLE_COUNT(SETTLE_COUNT)) u_settle
    (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_enable  (enable_r),
        .i_osc_run (i_osc_run),
        .o_stable  (stable)
    );

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            enable_r <= MON_CTRL_RST[BIT_ENABLE];
            level_r  <= LEVEL_RST;
        end
        else if (wr_acc && hit(i_paddr, ADDR_MON_CTRL))
        begin
            enable_r <= i_pwdata[BIT_ENABLE];
            // The reserved code is refused and the previous level kept.
            if (i_pwdata[2:0] != LEVEL_RSVD)
                level_r <= i_pwdata[2:0];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            irq_ctrl_r <= IRQ_CTRL_RST;
            pie_r      <= PIE_SEC_RST;
            sleep_r    <= 1'b0;
        end
        else
        begin
            if (wr_acc && hit(i_paddr, ADDR_IRQ_CTRL))
                irq_ctrl_r <= i_pwdata[7:0];
            if (wr_acc && hit(i_paddr, ADDR_PIE_SEC))
                pie_r <= i_pwdata[7:0] & PIE_SEC_MASK;
            if (wr_acc && hit(i_paddr, ADDR_SLEEP))
                sleep_r <= i_pwdata[0];
            else if (o_wake)
                sleep_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Flag register
    // ------------------------------------------------------------------
    // A detection in the same cycle as a software clear wins, so no event is lost.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            pir_r <= PIR_SEC_RST;
        else
        begin
            if (wr_acc && hit(i_paddr, ADDR_PIR_SEC))
                pir_r <= i_pwdata[7:0] & PIE_SEC_MASK;
            if (cmp_fall && enable_r)
                pir_r[BIT_FSUP] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt, wake and vector outputs
    // ------------------------------------------------------------------
    wire logic flag_en = pir_r[BIT_FSUP] & pie_r[BIT_FSUP];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_irq      <= 1'b0;
            o_wake     <= 1'b0;
            vec_pend_r <= 1'b0;
            o_vector   <= 1'b0;
        end
        else
        begin
            o_irq  <= flag_en & irq_ctrl_r[BIT_PERIPHERAL_IRQ_ENABLE] & irq_ctrl_r[BIT_GIE];
            o_wake <= sleep_r & ~o_wake & flag_en & irq_ctrl_r[BIT_PERIPHERAL_IRQ_ENABLE];
            if (o_wake && irq_ctrl_r[BIT_GIE])
                vec_pend_r <= 1'b1;
            else if (vec_pend_r && i_first_insn_done)
                vec_pend_r <= 1'b0;
            o_vector <= vec_pend_r & i_first_insn_done;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_det_power  <= 1'b0;
            o_trip_level <= LEVEL_RST;
        end
        else
        begin
            o_det_power  <= enable_r;
            o_trip_level <= level_r;
        end
    end

    // ------------------------------------------------------------------
    // APB read and answer
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~mapped;
            if (rd_acc)
            begin
                o_prdata <= PSLVERR_NONE;
                if (hit(i_paddr, ADDR_MON_CTRL))
                    o_prdata <= {26'h0, stable, enable_r, 1'b0, level_r};
                else if (hit(i_paddr, ADDR_IRQ_CTRL))
                    o_prdata <= {24'h0, irq_ctrl_r};
                else if (hit(i_paddr, ADDR_PIE_SEC))
                    o_prdata <= {24'h0, pie_r};
                else if (hit(i_paddr, ADDR_PIR_SEC))
                    o_prdata <= {24'h0, pir_r};
                else if (hit(i_paddr, ADDR_SLEEP))
                    o_prdata <= {30'h0, cmp_level, sleep_r};
            end
        end
    end
endmodule : sdm_top
`default_nettype wire

// ---- sdm_pkg.sv ----
// Package of constants and types for the supply drop monitor controller.
// Notes on behaviour
// - Setting the monitor enable bit powers up the detector and reference, clearing it powers both down.
// - A three-bit trip level field selects the threshold, codes 001 to 111 ascending and code 000 reserved.
// - A falling edge of the synchronised comparator output sets the falling-supply flag while the monitor enable bit is set.
// - The falling-supply flag holds until software clears it, a recovering supply never clears it.
// - The interrupt request is raised only when the flag, its enable, the peripheral and global enables are set.
// - A software write that sets the flag acts like a real detection and raises the interrupt likewise.
// - The read-only reference-stable bit reads 1 once the reference settled, meaningful only with the fast oscillator.
// - In Sleep a set flag with its enable and the peripheral enable set wakes the device.
// - If the global enable is also set at wake, the device vectors after the first instruction after wake.
// - On every reset the trip level is 100, enable and status bits are 0, unimplemented bits read 0; the comparator level bit at the sleep address resets to 1.
package sdm_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_MON_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_IRQ_CTRL  = 12'h004;
    localparam logic [11:0] ADDR_PIE_SEC   = 12'h008;
    localparam logic [11:0] ADDR_PIR_SEC   = 12'h00C;
    localparam logic [11:0] ADDR_SLEEP     = 12'h010;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          BIT_STABLE     = 5;
    localparam int          BIT_ENABLE     = 4;
    localparam int          BIT_GIE        = 7;
    localparam int          BIT_PERIPHERAL_IRQ_ENABLE       = 6;
    localparam int          BIT_FSUP       = 2;
    localparam logic [7:0]  MON_CTRL_RST   = 8'h04;
    localparam logic [2:0]  LEVEL_RST      = 3'h4;
    localparam logic [2:0]  LEVEL_RSVD     = 3'h0;
    localparam logic [7:0]  IRQ_CTRL_RST   = 8'h00;
    localparam logic [7:0]  PIE_SEC_RST    = 8'h00;
    localparam logic [7:0]  PIR_SEC_RST    = 8'h00;
    localparam logic [7:0]  PIE_SEC_MASK   = 8'hF5;
    localparam logic [31:0] PSLVERR_NONE   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ        = 200;
    localparam int          SETTLE_US      = 100;
    localparam int          SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;

    typedef enum logic [1:0]
    {
        REF_OFF    = 2'b00,
        REF_SETTLE = 2'b01,
        REF_STABLE = 2'b11
    } sdm_ref_state_t;
endpackage : sdm_pkg

// ---- sdm_sync.sv ----
// Two-flop synchroniser with a falling-edge pulse from the synchronised level.
`timescale 1ns/100ps
`default_nettype none
module sdm_sync
    import sdm_pkg::*;
(
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    // Level in and results
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // The reset value is high so a supply already low at release still shows a fall.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_fall  = prev_r & ~sync_r;
endmodule : sdm_sync
`default_nettype wire

// ---- sdm_settle.sv ----
// Reference settling timer that reports when the reference is stable.
`timescale 1ns/100ps
`default_nettype none
module sdm_settle
    import sdm_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
)
(
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    // Control and status
    input  wire logic i_enable,
    input  wire logic i_osc_run,
    output logic      o_stable
);
    sdm_ref_state_t state_r;
    logic [31:0]    cnt_r;

    // A zero count would wrap the compare to all ones and stall settling, so it is refused when the design is built.
    if (SETTLE_COUNT < 1)
    begin : g_bad_count
        $error("SETTLE_COUNT must be at least one");
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset || !i_enable)
        begin
            state_r <= REF_OFF;
            cnt_r   <= 32'h0000_0000;
        end
        else
        begin
            case (state_r)
                REF_OFF:
                begin
                    state_r <= REF_SETTLE;
                    cnt_r   <= 32'h0000_0000;
                end
                REF_SETTLE:
                begin
                    if (cnt_r >= 32'(SETTLE_COUNT - 1))
                        state_r <= REF_STABLE;
                    else
                        cnt_r <= cnt_r + 32'h0000_0001;
                end
                REF_STABLE:
                    state_r <= REF_STABLE;
                default:
                    state_r <= REF_OFF;
            endcase
        end
    end

    // Without the fast oscillator the status cannot be trusted, so it reads 0.
    assign o_stable = (state_r == REF_STABLE) && i_osc_run;
endmodule : sdm_settle
`default_nettype wire

// ---- sdm_properties.sv ----
// Concurrent checks on the ports of the supply drop monitor controller.
`timescale 1ns/100ps
`default_nettype none
module sdm_properties
    import sdm_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_reset,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_osc_run,
    input wire logic        o_det_power,
    input wire logic [2:0]  o_trip_level,
    input wire logic        i_first_insn_done,
    input wire logic        o_irq,
    input wire logic        o_wake,
    input wire logic        o_vector
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_wr_ctrl;
        i_psel && i_penable && i_pwrite && i_pstrb[0] && i_paddr == ADDR_MON_CTRL;
    endsequence
    sequence s_rd_ctrl;
        s_setup and (!i_pwrite && i_paddr == ADDR_MON_CTRL);
    endsequence

    a_ready_after_setup: assert property (s_setup |=> o_pready)
        else $error("pready missing after setup");
    a_error_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    a_level_write: assert property (s_wr_ctrl |-> ##2 o_trip_level ==
        (($past(i_pwdata[2:0], 2) == LEVEL_RSVD) ? $past(o_trip_level) : $past(i_pwdata[2:0], 2)))
        else $error("trip level not written as expected");
    a_power_follows_en: assert property (s_wr_ctrl |-> ##2 o_det_power == $past(i_pwdata[4], 2))
        else $error("detector power does not follow enable");
    a_upper_bits_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_ctrl_read_bits: assert property (s_rd_ctrl |=> o_prdata[7:6] == 2'b00 && !o_prdata[3]
        && ($past(i_osc_run) || !o_prdata[BIT_STABLE]))
        else $error("control read shows bad bits");
    a_wake_one_cycle: assert property (o_wake |=> !o_wake)
        else $error("wake longer than one cycle");
    a_vector_after_insn: assert property (o_vector |-> $past(i_first_insn_done))
        else $error("vector without completed instruction");
    a_reset_outputs: assert property (disable iff (1'b0) i_reset |=> o_trip_level == LEVEL_RST
        && !o_irq && !o_wake && !o_vector && !o_det_power)
        else $error("outputs wrong after reset");
endmodule : sdm_properties
`default_nettype wire

// ---- sdm_cmp_model.sv ----
// Behavioural trip comparator watching a modelled supply voltage.
`timescale 1ns/100ps
`default_nettype none
module sdm_cmp_model
#(
    parameter int LAG_NS = 0
)
(
    // Supply and control
    input  wire logic        i_power,
    input  wire logic [2:0]  i_level,
    input  wire logic [15:0] i_supply_mv,
    // Result
    output logic             o_above
);
    logic [15:0] trip_mv;
    always_comb
    begin
        case (i_level)
            3'h1: trip_mv = 16'h07D0;
            3'h2: trip_mv = 16'h0834;
            3'h3: trip_mv = 16'h0898;
            3'h4: trip_mv = 16'h08FC;
            3'h5: trip_mv = 16'h0FA0;
            3'h6: trip_mv = 16'h1068;
            3'h7: trip_mv = 16'h1194;
            default: trip_mv = 16'h0000;
        endcase
    end
    // An unpowered comparator idles high, so power-down never fakes a trip.
    assign #(LAG_NS) o_above = !i_power || (i_supply_mv > trip_mv);
endmodule : sdm_cmp_model
`default_nettype wire

// ---- supply_drop_monitor_ctrl_bench.sv ----
// Self-checking bench for the supply drop monitor controller.
`timescale 1ns/100ps
`default_nettype none
module supply_drop_monitor_ctrl_bench;
    import sdm_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} sdm_row_t;
    logic        clk, rst, psel, pen, pwr, pready, perr, cmp, osc, pow, insn, irq, wake, vec, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [2:0]  lvl;
    logic [15:0] supply;
    int          errors, total_checks, vec_cnt, n;
    sdm_row_t    rows[7];

    sdm_top #(.SETTLE_COUNT(4)) dut (.i_sys_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .i_cmp_above(cmp), .i_osc_run(osc), .o_det_power(pow),
        .o_trip_level(lvl), .i_first_insn_done(insn), .o_irq(irq), .o_wake(wake), .o_vector(vec));
    sdm_cmp_model #(.LAG_NS(3)) u_cmp (.i_power(pow), .i_level(lvl), .i_supply_mv(supply), .o_above(cmp));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // Only the watchdog ends a wait that never sees pready.
        while (pready !== 1'b1)
            @(posedge clk);
        rdat = prdata;
        rerr = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string msg);
        apb(1'b0, a, 32'h0);
        check(rdat, x, msg);
    endtask : rdc

    task automatic wait_wake();
        n = 0;
        while (wake !== 1'b1 && n < 30)
        begin
            @(posedge clk);
            n++;
        end
        check(wake, 1'b1, "wake pulse");
        insn <= 1'b1;
        @(posedge clk);
        insn <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : wait_wake

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
        if (vec === 1'b1)
            vec_cnt++;

    initial
    begin
        repeat (4000) @(posedge clk);
        errors++;
        $display("ERROR %0t timeout", $time);
        summarize();
    end

    initial
    begin
        {rst, psel, pen, pwr, insn, paddr, pwdata} = '0;
        rst    = 1'b1;
        osc    = 1'b1;
        pstrb  = 4'hF;
        supply = 16'h0CE4;
        rows = '{'{ADDR_MON_CTRL, 32'hEF, 32'h07, 1'b0}, '{ADDR_MON_CTRL, 32'h00, 32'h07, 1'b0},
                 '{ADDR_MON_CTRL, 32'h02, 32'h02, 1'b0}, '{ADDR_IRQ_CTRL, 32'h3F, 32'h3F, 1'b0},
                 '{ADDR_PIE_SEC, 32'hFF, 32'hF5, 1'b0}, '{ADDR_PIR_SEC, 32'h00, 32'h00, 1'b0},
                 '{12'h020, 32'hFF, 32'h00, 1'b1}};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        check({pow, irq, wake, vec, lvl}, 32'h04, "outputs after reset");
        rdc(ADDR_MON_CTRL, 32'h04, "control reset");
        rdc(ADDR_PIR_SEC, 32'h00, "flag reset");
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].x, "register readback");
            check(rerr, rows[i].e, "slave error");
        end
        $display("test registers done");
        apb(1'b1, ADDR_MON_CTRL, 32'h14);
        repeat (12) @(posedge clk);
        check({pow, lvl}, 32'h0C, "detector powered");
        rdc(ADDR_MON_CTRL, 32'h34, "reference stable");
        osc <= 1'b0;
        rdc(ADDR_MON_CTRL, 32'h14, "stable hidden without oscillator");
        osc <= 1'b1;
        repeat (12) @(posedge clk);
        apb(1'b1, ADDR_PIR_SEC, 32'h00);
        apb(1'b1, ADDR_PIE_SEC, 32'h04);
        apb(1'b1, ADDR_IRQ_CTRL, 32'hC0);
        supply <= 16'h07D0;
        repeat (10) @(posedge clk);
        check(irq, 1'b1, "trip raises request");
        supply <= 16'h0CE4;
        repeat (10) @(posedge clk);
        rdc(ADDR_PIR_SEC, 32'h04, "flag sticky");
        apb(1'b1, ADDR_PIR_SEC, 32'h00);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "request cleared");
        apb(1'b1, ADDR_IRQ_CTRL, 32'h40);
        apb(1'b1, ADDR_PIR_SEC, 32'h04);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "global mask");
        apb(1'b1, ADDR_IRQ_CTRL, 32'hC0);
        repeat (2) @(posedge clk);
        check(irq, 1'b1, "software event");
        apb(1'b1, ADDR_IRQ_CTRL, 32'h80);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "peripheral mask");
        $display("test detection done");
        apb(1'b1, ADDR_IRQ_CTRL, 32'h40);
        apb(1'b1, ADDR_PIR_SEC, 32'h00);
        apb(1'b1, ADDR_SLEEP, 32'h01);
        supply <= 16'h07D0;
        wait_wake();
        rdc(ADDR_SLEEP, 32'h00, "sleep released");
        check(vec_cnt, 0, "no vector without global enable");
        supply <= 16'h0CE4;
        apb(1'b1, ADDR_IRQ_CTRL, 32'hC0);
        apb(1'b1, ADDR_PIR_SEC, 32'h00);
        apb(1'b1, ADDR_SLEEP, 32'h01);
        apb(1'b1, ADDR_PIR_SEC, 32'h04);
        wait_wake();
        check(vec_cnt, 1, "vector after first instruction");
        $display("test sleep done");
        apb(1'b1, ADDR_MON_CTRL, 32'h04);
        apb(1'b1, ADDR_PIR_SEC, 32'h00);
        supply <= 16'h07D0;
        repeat (10) @(posedge clk);
        check({pow, lvl}, 32'h04, "detector powered down");
        rdc(ADDR_PIR_SEC, 32'h00, "no detection while disabled");
        $display("test disable done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_MON_CTRL, 32'h04, "control after second reset");
        check({pow, irq}, 32'h0, "outputs after second reset");
        $display("test second reset done");
        summarize();
    end
endmodule : supply_drop_monitor_ctrl_bench

bind sdm_top sdm_properties u_props (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_osc_run(i_osc_run),
    .o_det_power(o_det_power), .o_trip_level(o_trip_level), .i_first_insn_done(i_first_insn_done),
    .o_irq(o_irq), .o_wake(o_wake), .o_vector(o_vector));
`default_nettype wire
